// *** rtl/stopwatch_control.sv ***
/*
 stopwatch_control: bcd stopwatch count, run/stop control synchronised to a
 256 hz tick, and 1/10/100 hz interrupt flags with enables and priority.
 assumes an axi4-lite master on clk and a cpu mask level on cpuMaskLevel.
*/
`timescale 1ns/100ps
// Contract
// R1: writing one to the clear bit zeroes both bcd digits
// R2: clear while running resumes counting from zero; while stopped holds zero
// R3: clear bit is write-only, zero writes ignored, reads return zero
// R4: run bit one counts upward, zero stops
// R5: stopped count holds until cleared, resumes from held value
// R6: run bit reads zero after reset
// R7: two-bit priority gives level 0 to 3, resets to zero
// R8: three read/write enables for 1, 10, 100 hz, reset zero
// R9: each flag sets on the falling edge of its rate signal
// R10: flags set regardless of enable and priority
// R11: request only when flag, enable, and priority above cpu mask
// R12: writing one clears a flag, zero leaves it; reset clears
// R13: software lowers mask or returns and clears flag before next interrupt
// R14: run bit write takes effect at next falling 256 hz tick
// R15: after stop write, count advances once more; run reads one until stopped
// R16: software should stop the stopwatch before sleeping
// R17: count is read-only eight-bit bcd, tenths high, hundredths low
// R18: hundredths advances at 100 hz, carries to tenths; rates from digits
module stopwatch_control #(
   parameter int ClkHz = stopwatch_pkg::ClkHz
) (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic [15:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [15:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [1:0]  cpuMaskLevel,
   output logic             irqRequest,
   output logic [1:0]       irqLevel,
   output logic             irqLine
);
   localparam int TickW = 17;
   localparam int HundW = 18;
   localparam logic [TickW-1:0] TickMax = TickW'(ClkHz / stopwatch_pkg::TickHz - 1);
   localparam logic [HundW-1:0] HundMax = HundW'(ClkHz / stopwatch_pkg::HundredHz - 1);

   logic [TickW-1:0] tickCnt_q;
   logic             tickFall;
   logic [HundW-1:0] hundCnt_q;
   logic             hundStep;
   logic [3:0]       hundredths_q;
   logic [3:0]       tenths_q;
   logic             runReq_q;
   logic             runReqPend_q;
   logic             running_q;
   logic             stopPend_q;
   logic [1:0]       level_q;
   logic [2:0]       allow_q;
   logic [2:0]       flags_q;
   logic [2:0]       irqMask_q;
   logic [2:0]       rateFall;
   logic             awHeld_q;
   logic             wHeld_q;
   logic [15:0]      awAddr_q;
   logic [31:0]      wData_q;
   logic [3:0]       wStrb_q;
   logic             doWrite;
   logic             wrLow;
   logic             clearHit;
   logic             runWrite;
   logic [31:0]      rdValue;
   logic             rdHit;

   // 256 hz tick divider, falling edge as one-cycle pulse
   always_ff @(posedge clk) begin
      if (srst || tickCnt_q == TickMax) begin
         tickCnt_q <= '0;
      end else begin
         tickCnt_q <= tickCnt_q + 1'b1;
      end
   end
   assign tickFall = (tickCnt_q == TickMax);

   // 100 hz count step, gated by running
   always_ff @(posedge clk) begin
      if (srst || clearHit || hundCnt_q == HundMax) begin
         hundCnt_q <= '0;
      end else if (running_q) begin
         hundCnt_q <= hundCnt_q + 1'b1;
      end
   end
   assign hundStep = running_q && (hundCnt_q == HundMax);

   // axi write channels, accepted in either order
   assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
   assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
   always_ff @(posedge clk) begin
      if (srst || doWrite) begin
         awHeld_q <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeld_q <= 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (srst || doWrite) begin
         wHeld_q <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeld_q <= 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         awAddr_q <= 16'h0000;
         wData_q  <= 32'h00000000;
         wStrb_q  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
      end
   end
   assign doWrite = awHeld_q && wHeld_q;
   assign wrLow   = doWrite && wStrb_q[0];

   always_ff @(posedge clk) begin
      if (srst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= stopwatch_pkg::RespOkay;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         if (awAddr_q == stopwatch_pkg::LevelAddr || awAddr_q == stopwatch_pkg::AllowAddr
             || awAddr_q == stopwatch_pkg::FlagAddr || awAddr_q == stopwatch_pkg::RunClrAddr
             || awAddr_q == stopwatch_pkg::MaskAddr || awAddr_q == stopwatch_pkg::CountAddr) begin
            s_axi_bresp <= stopwatch_pkg::RespOkay;
         end else begin
            s_axi_bresp <= stopwatch_pkg::RespSlvErr;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   assign clearHit = wrLow && awAddr_q == stopwatch_pkg::RunClrAddr
                     && wData_q[stopwatch_pkg::ClearPos]; // R1 R3
   assign runWrite = wrLow && awAddr_q == stopwatch_pkg::RunClrAddr;

   // requested run value waits for the next tick
   always_ff @(posedge clk) begin
      if (srst) begin
         runReq_q     <= 1'b0;
         runReqPend_q <= 1'b0;
      end else if (runWrite) begin
         runReq_q     <= wData_q[stopwatch_pkg::RunPos]; // R4
         runReqPend_q <= 1'b1;
      end else if (tickFall) begin
         runReqPend_q <= 1'b0;
      end
   end

   // run state: start at tick, stop after one more count step
   always_ff @(posedge clk) begin
      if (srst) begin
         running_q  <= 1'b0; // R6
         stopPend_q <= 1'b0;
      end else if (tickFall && runReqPend_q && !runWrite) begin
         if (runReq_q) begin
            running_q  <= 1'b1; // R14
            stopPend_q <= 1'b0;
         end else if (running_q) begin
            stopPend_q <= 1'b1; // R15
         end
      end else if (stopPend_q && hundStep) begin
         running_q  <= 1'b0; // R15
         stopPend_q <= 1'b0;
      end
   end

   // bcd count, clear dominates
   always_ff @(posedge clk) begin
      if (srst || clearHit) begin
         hundredths_q <= stopwatch_pkg::CountReset[3:0]; // R1 R2 R17
         tenths_q     <= stopwatch_pkg::CountReset[7:4];
      end else if (hundStep) begin
         if (hundredths_q == 4'h9) begin
            hundredths_q <= 4'h0; // R18
            tenths_q     <= (tenths_q == 4'h9) ? 4'h0 : tenths_q + 4'h1;
         end else begin
            hundredths_q <= hundredths_q + 4'h1; // R4 R5
         end
      end
   end

   // rate signals fall at digit transitions
   assign rateFall[0] = hundStep && hundredths_q == 4'h9 && tenths_q == 4'h9; // R9 R18
   assign rateFall[1] = hundStep && hundredths_q == 4'h9; // R9 R18
   assign rateFall[2] = hundStep; // R9 R18

   // priority, enable, irq line mask registers
   always_ff @(posedge clk) begin
      if (srst) begin
         level_q   <= stopwatch_pkg::LevelReset; // R7
         allow_q   <= stopwatch_pkg::AllowReset; // R8
         irqMask_q <= 3'h0;
      end else if (wrLow) begin
         if (awAddr_q == stopwatch_pkg::LevelAddr) begin
            level_q <= wData_q[stopwatch_pkg::LevelHighPos:stopwatch_pkg::LevelLowPos];
         end else if (awAddr_q == stopwatch_pkg::AllowAddr) begin
            allow_q <= wData_q[stopwatch_pkg::HundredHzPos:stopwatch_pkg::OneHzPos];
         end else if (awAddr_q == stopwatch_pkg::MaskAddr) begin
            irqMask_q <= wData_q[stopwatch_pkg::HundredHzPos:stopwatch_pkg::OneHzPos];
         end
      end
   end

   // factor flags: set wins over write-one clear
   always_ff @(posedge clk) begin
      if (srst) begin
         flags_q <= stopwatch_pkg::FlagReset; // R12
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (rateFall[i]) begin
               flags_q[i] <= 1'b1; // R10
            end else if (wrLow && awAddr_q == stopwatch_pkg::FlagAddr
                         && wData_q[stopwatch_pkg::OneHzPos + i]) begin
               flags_q[i] <= 1'b0; // R12
            end
         end
      end
   end

   assign irqRequest = |(flags_q & allow_q) && (level_q > cpuMaskLevel); // R11
   assign irqLevel   = level_q; // R7
   assign irqLine    = |(flags_q & irqMask_q);

   // read channel
   always_comb begin
      rdValue = 32'h00000000;
      rdHit   = 1'b1;
      if (s_axi_araddr == stopwatch_pkg::LevelAddr) begin
         rdValue[stopwatch_pkg::LevelHighPos:stopwatch_pkg::LevelLowPos] = level_q;
      end else if (s_axi_araddr == stopwatch_pkg::AllowAddr) begin
         rdValue[stopwatch_pkg::HundredHzPos:stopwatch_pkg::OneHzPos] = allow_q;
      end else if (s_axi_araddr == stopwatch_pkg::FlagAddr) begin
         rdValue[stopwatch_pkg::HundredHzPos:stopwatch_pkg::OneHzPos] = flags_q;
      end else if (s_axi_araddr == stopwatch_pkg::RunClrAddr) begin
         rdValue[stopwatch_pkg::RunPos] = running_q || (runReqPend_q && runReq_q); // R3 R15
      end else if (s_axi_araddr == stopwatch_pkg::CountAddr) begin
         rdValue[7:0] = {tenths_q, hundredths_q}; // R17
      end else if (s_axi_araddr == stopwatch_pkg::MaskAddr) begin
         rdValue[stopwatch_pkg::HundredHzPos:stopwatch_pkg::OneHzPos] = irqMask_q;
      end else begin
         rdHit = 1'b0;
      end
   end
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clk) begin
      if (srst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= stopwatch_pkg::RespOkay;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rdValue;
         s_axi_rresp  <= rdHit ? stopwatch_pkg::RespOkay : stopwatch_pkg::RespSlvErr;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // assertions
   clear_zeroes_a: assert property (@(posedge clk) disable iff (srst)
      clearHit |=> {tenths_q, hundredths_q} == 8'h00) else $error("clear missed"); // R1
   hold_stopped_a: assert property (@(posedge clk) disable iff (srst)
      !running_q && !clearHit |=> $stable({tenths_q, hundredths_q}))
      else $error("count moved while stopped"); // R5
   start_at_tick_a: assert property (@(posedge clk) disable iff (srst)
      $rose(running_q) |-> $past(tickFall)) else $error("start off tick"); // R14
   stop_after_step_a: assert property (@(posedge clk) disable iff (srst)
      $fell(running_q) |-> $past(hundStep)) else $error("stop without step"); // R15
   flag_set_a: assert property (@(posedge clk) disable iff (srst)
      rateFall[2] |=> flags_q[2]) else $error("flag not set"); // R10
   flag_clear_a: assert property (@(posedge clk) disable iff (srst)
      wrLow && awAddr_q == stopwatch_pkg::FlagAddr && wData_q[4] && !rateFall[0]
      |=> !flags_q[0]) else $error("flag not cleared"); // R12
   irq_gate_a: assert property (@(posedge clk) disable iff (srst)
      irqRequest |-> level_q > cpuMaskLevel && |(flags_q & allow_q))
      else $error("bad request"); // R11
   clear_read_a: assert property (@(posedge clk) disable iff (srst)
      s_axi_rvalid |-> !s_axi_rdata[stopwatch_pkg::ClearPos]) else $error("clear bit read"); // R3
   digit_bcd_a: assert property (@(posedge clk) disable iff (srst)
      hundredths_q <= 4'h9 && tenths_q <= 4'h9) else $error("not bcd"); // R17
   run_cover_c: cover property (@(posedge clk) $rose(running_q));
   stop_cover_c: cover property (@(posedge clk) $fell(running_q));
   irq_cover_c: cover property (@(posedge clk) $rose(irqRequest));
   ten_hz_c: cover property (@(posedge clk) rateFall[1]);
   one_hz_c: cover property (@(posedge clk) rateFall[0]);

   // run control, count, flag, interrupt and register checks
   stop_pend_run_a: assert property (@(posedge clk) disable iff (srst) // R15
      stopPend_q |-> running_q)
      else $error("stop pending while stopped");
   flag_ten_a: assert property (@(posedge clk) disable iff (srst) // R9
      rateFall[1] |=> flags_q[1])
      else $error("ten hz flag not set");
   flag_one_a: assert property (@(posedge clk) disable iff (srst) // R9
      rateFall[0] |=> flags_q[0])
      else $error("one hz flag not set");
   step_inc_a: assert property (@(posedge clk) disable iff (srst) // R18
      hundStep && !clearHit && hundredths_q != 4'h9 |=> hundredths_q == $past(hundredths_q) + 4'h1)
      else $error("hundredths did not advance");
   carry_wrap_a: assert property (@(posedge clk) disable iff (srst) // R18
      hundStep && !clearHit && hundredths_q == 4'h9 |=> hundredths_q == 4'h0)
      else $error("hundredths did not wrap");
   tenths_carry_a: assert property (@(posedge clk) disable iff (srst) // R18
      hundStep && !clearHit && hundredths_q == 4'h9 && tenths_q != 4'h9
      |=> tenths_q == $past(tenths_q) + 4'h1)
      else $error("tenths did not carry");
   no_step_stop_a: assert property (@(posedge clk) disable iff (srst) // R5
      !running_q |-> !hundStep)
      else $error("step while stopped");
   tick_single_a: assert property (@(posedge clk) disable iff (srst) // R14
      tickFall |=> !tickFall)
      else $error("tick longer than one cycle");
   run_pend_a: assert property (@(posedge clk) disable iff (srst) // R14
      runWrite |=> runReqPend_q)
      else $error("run write not pending");
   flag_hold_a: assert property (@(posedge clk) disable iff (srst) // R12
      flags_q[2] && !(wrLow && awAddr_q == stopwatch_pkg::FlagAddr) |=> flags_q[2])
      else $error("flag dropped without clear");
   flag_w0_a: assert property (@(posedge clk) disable iff (srst) // R12
      wrLow && awAddr_q == stopwatch_pkg::FlagAddr && !wData_q[6] && flags_q[2] |=> flags_q[2])
      else $error("zero write cleared flag");
   irq_off_a: assert property (@(posedge clk) disable iff (srst) // R11
      !(|(flags_q & allow_q)) |-> !irqRequest)
      else $error("request without enabled flag");
   irq_on_a: assert property (@(posedge clk) disable iff (srst) // R11
      |(flags_q & allow_q) && level_q > cpuMaskLevel |-> irqRequest)
      else $error("request missing");
   level_zero_a: assert property (@(posedge clk) disable iff (srst) // R7
      level_q == 2'h0 |-> !irqRequest)
      else $error("request at level zero");
   allow_write_a: assert property (@(posedge clk) disable iff (srst) // R8
      wrLow && awAddr_q == stopwatch_pkg::AllowAddr |=> allow_q == wData_q[6:4])
      else $error("enable write lost");
   level_write_a: assert property (@(posedge clk) disable iff (srst) // R7
      wrLow && awAddr_q == stopwatch_pkg::LevelAddr |=> level_q == wData_q[3:2])
      else $error("priority write lost");
   count_ro_a: assert property (@(posedge clk) disable iff (srst) // R17
      wrLow && awAddr_q == stopwatch_pkg::CountAddr && !hundStep
      |=> $stable({tenths_q, hundredths_q}))
      else $error("count written");
   reset_state_a: assert property (@(posedge clk) // R6
      srst |=> !running_q && flags_q == 3'h0 && level_q == 2'h0 && allow_q == 3'h0)
      else $error("reset state wrong");

   // bus handshake checks
   bvalid_hold_a: assert property (@(posedge clk) disable iff (srst)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   rvalid_hold_a: assert property (@(posedge clk) disable iff (srst)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response dropped");
   write_busy_a: assert property (@(posedge clk) disable iff (srst)
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   read_busy_a: assert property (@(posedge clk) disable iff (srst)
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
endmodule : stopwatch_control

// *** rtl/stopwatch_pkg.sv ***
/*
 stopwatch_pkg: register offsets, field positions, reset values and timing
 counts shared by the stopwatch control and interrupt block.
 assumes a 20 MHz system clock and a 32-bit axi4-lite register bus.
*/
package stopwatch_pkg;
   // byte addresses of the registers
   localparam logic [15:0] LevelAddr   = 16'hff20;
   localparam logic [15:0] AllowAddr   = 16'hff22;
   localparam logic [15:0] FlagAddr    = 16'hff24;
   localparam logic [15:0] RunClrAddr  = 16'hff42;
   localparam logic [15:0] CountAddr   = 16'hff43;
   localparam logic [15:0] MaskAddr    = 16'hff60;
   // field positions
   localparam int LevelLowPos  = 2;
   localparam int LevelHighPos = 3;
   localparam int OneHzPos     = 4;
   localparam int TenHzPos     = 5;
   localparam int HundredHzPos = 6;
   localparam int RunPos       = 0;
   localparam int ClearPos     = 1;
   // reset values
   localparam logic [1:0] LevelReset = 2'h0;
   localparam logic [2:0] AllowReset = 3'h0;
   localparam logic [2:0] FlagReset  = 3'h0;
   localparam logic [7:0] CountReset = 8'h00;
   localparam logic [1:0] MaskReset  = 2'h0;
   // timing and bus response codes
   localparam int ClkHz       = 20000000;
   localparam int TickHz      = 256;
   localparam int TickCycles  = ClkHz / TickHz;
   localparam int HundredHz   = 100;
   localparam int HundredCycles = ClkHz / HundredHz;
   localparam logic [1:0] RespOkay   = 2'h0;
   localparam logic [1:0] RespSlvErr = 2'h2;
endpackage : stopwatch_pkg

// *** testbench/cpu_mask_model.sv ***
/*
 cpu_mask_model: cpu side of the interrupt request, holding the mask level.
 assumes irqRequest and irqLevel from the stopwatch block on the same clk.
*/
`timescale 1ns/100ps
module cpu_mask_model (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       irqRequest,
   input  wire logic [1:0] irqLevel,
   input  wire logic       returnReq,
   output logic [1:0]      cpuMaskLevel
);
   // accepting a request lifts the mask to its level; return drops it
   always_ff @(posedge clk) begin
      if (srst) begin
         cpuMaskLevel <= 2'h0;
      end else if (returnReq) begin
         cpuMaskLevel <= 2'h0;
      end else if (irqRequest) begin
         cpuMaskLevel <= irqLevel;
      end
   end
endmodule : cpu_mask_model

// *** testbench/tb_top.sv ***
/*
 tb_top: register-level tests of the stopwatch control block.
 assumes a scaled clock rate parameter: 100-cycle tick and 256-cycle step.
*/
`timescale 1ns/100ps
module tb_top;
   logic        clk, srst, awvalid, wvalid, bready, arvalid, rready, returnReq;
   logic        awready, wready, bvalid, arready, rvalid, irqRequest, irqLine;
   logic [15:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, irqLevel, cpuMaskLevel, resp;
   int          errors, num_checks;

   stopwatch_control #(.ClkHz(25600)) stopwatch_control_inst (.clk(clk), .srst(srst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpuMaskLevel(cpuMaskLevel),
      .irqRequest(irqRequest), .irqLevel(irqLevel), .irqLine(irqLine));

   cpu_mask_model cpu_mask_model_inst (.clk(clk), .srst(srst), .irqRequest(irqRequest),
      .irqLevel(irqLevel), .returnReq(returnReq), .cpuMaskLevel(cpuMaskLevel));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task print_verdict;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : print_verdict

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      logic aOk, wOk, sa, sw;
      aOk = 0;
      wOk = 0;
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aOk && wOk)) begin
         @(negedge clk);
         sa = awready && !aOk;
         sw = wready && !wOk;
         @(posedge clk);
         if (sa) begin aOk = 1; awvalid <= 1'b0; end
         if (sw) begin wOk = 1; wvalid <= 1'b0; end
      end
      do begin @(negedge clk); sa = bvalid; resp = bresp; @(posedge clk); end while (!sa);
      bready <= 1'b0;
   endtask : wr

   task automatic rdReg(input logic [15:0] a);
      logic s;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin @(negedge clk); s = arready; @(posedge clk); end while (!s);
      arvalid <= 1'b0;
      do begin @(negedge clk); s = rvalid; rd = rdata; resp = rresp; @(posedge clk); end
      while (!s);
      rready <= 1'b0;
   endtask : rdReg

   task automatic rdChk(input logic [15:0] a, input logic [31:0] exp);
      rdReg(a);
      check(rd, exp, "read data");
      check({30'h0, resp}, {30'h0, stopwatch_pkg::RespOkay}, "read resp");
   endtask : rdChk

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      print_verdict();
   end

   initial begin
      srst = 1'b1; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
      returnReq = 0; awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'hf;
      errors = 0; num_checks = 0;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      rdChk(stopwatch_pkg::LevelAddr, 32'h0);
      rdChk(stopwatch_pkg::AllowAddr, 32'h0);
      rdChk(stopwatch_pkg::FlagAddr, 32'h0);
      rdChk(stopwatch_pkg::RunClrAddr, 32'h0);
      rdChk(stopwatch_pkg::CountAddr, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wr(stopwatch_pkg::LevelAddr, 32'(i) << 2);
         rdChk(stopwatch_pkg::LevelAddr, 32'(i) << 2);
         check({30'h0, irqLevel}, 32'(i), "irq level");
      end
      wr(stopwatch_pkg::AllowAddr, 32'h70);
      rdChk(stopwatch_pkg::AllowAddr, 32'h70);
      wr(stopwatch_pkg::AllowAddr, 32'h0);
      wr(stopwatch_pkg::RunClrAddr, 32'h2);
      rdChk(stopwatch_pkg::RunClrAddr, 32'h0);
      wr(stopwatch_pkg::CountAddr, 32'h99);
      rdChk(stopwatch_pkg::CountAddr, 32'h0);
      wr(16'hff30, 32'h1);
      check({30'h0, resp}, {30'h0, stopwatch_pkg::RespSlvErr}, "unmapped write");
      rdReg(16'hff30);
      check({30'h0, resp}, {30'h0, stopwatch_pkg::RespSlvErr}, "unmapped read");
      // run until the first 100 hz step raises its flag
      wr(stopwatch_pkg::MaskAddr, 32'h40);
      wr(stopwatch_pkg::LevelAddr, 32'hc);
      wr(stopwatch_pkg::RunClrAddr, 32'h1);
      rdChk(stopwatch_pkg::RunClrAddr, 32'h1);
      do @(negedge clk); while (irqLine !== 1'b1);
      check({31'h0, irqRequest}, 32'h0, "request while disabled");
      rdChk(stopwatch_pkg::FlagAddr, 32'h40);
      rdChk(stopwatch_pkg::CountAddr, 32'h01);
      wr(stopwatch_pkg::AllowAddr, 32'h40);
      @(negedge clk);
      check({30'h0, cpuMaskLevel}, 32'h3, "request accepted");
      check({31'h0, irqRequest}, 32'h0, "request at mask level");
      wr(stopwatch_pkg::FlagAddr, 32'h20);
      rdChk(stopwatch_pkg::FlagAddr, 32'h40);
      wr(stopwatch_pkg::FlagAddr, 32'h40);
      rdChk(stopwatch_pkg::FlagAddr, 32'h0);
      check({31'h0, irqLine}, 32'h0, "line after clear");
      returnReq <= 1'b1;
      @(posedge clk);
      returnReq <= 1'b0;
      @(negedge clk);
      check({31'h0, irqRequest}, 32'h0, "request after return");
      wr(stopwatch_pkg::RunClrAddr, 32'h2);
      rdChk(stopwatch_pkg::CountAddr, 32'h0);
      wr(stopwatch_pkg::RunClrAddr, 32'h0);
      rdChk(stopwatch_pkg::RunClrAddr, 32'h1);
      repeat (600) @(posedge clk);
      rdChk(stopwatch_pkg::RunClrAddr, 32'h0);
      rdChk(stopwatch_pkg::CountAddr, 32'h01);
      repeat (600) @(posedge clk);
      rdChk(stopwatch_pkg::CountAddr, 32'h01);
      wr(stopwatch_pkg::RunClrAddr, 32'h2);
      repeat (600) @(posedge clk);
      rdChk(stopwatch_pkg::CountAddr, 32'h0);
      wr(stopwatch_pkg::FlagAddr, 32'h70);
      wr(stopwatch_pkg::MaskAddr, 32'h20);
      wr(stopwatch_pkg::RunClrAddr, 32'h1);
      do @(negedge clk); while (irqLine !== 1'b1);
      rdChk(stopwatch_pkg::CountAddr, 32'h10);
      wr(stopwatch_pkg::MaskAddr, 32'h10);
      do @(negedge clk); while (irqLine !== 1'b1);
      rdChk(stopwatch_pkg::CountAddr, 32'h00);
      wr(stopwatch_pkg::RunClrAddr, 32'h0);
      repeat (600) @(posedge clk);
      rdChk(stopwatch_pkg::RunClrAddr, 32'h0);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rdChk(stopwatch_pkg::RunClrAddr, 32'h0);
      rdChk(stopwatch_pkg::FlagAddr, 32'h0);
      print_verdict();
   end
endmodule : tb_top
